// >>> test_tenbase_link_pulse_jabber_timer.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module test_tenbase_link_pulse_jabber_timer;
   import tlpj_pkg::*;
   localparam int NLP_P = 200;
   localparam int FLP_P = 6000;
   localparam int SPACE = 250;
   localparam int D_OFS = 124;
   localparam int JAB_T = 100;
   localparam int JAB_R = 300;
   logic                 i_mclk, i_reset, i_link_idle, i_an_enable;
   logic                 i_tx_active;
   logic [WORD_BITS-1:0] i_an_word;
   tlpj_pulse_t          o_pulse;
   logic                 o_burst_busy, o_word_taken, o_jabber, o_tx_enable;
   int width, period, d_ofs, n_clk, n_data, c0, d0, t0, k;
   int n_mismatch, checked, cycles;
   tlpj_link_timer #(.NLP_PERIOD(NLP_P), .FLP_PERIOD(FLP_P), .JAB_ON(JAB_T),
      .JAB_OFF(JAB_R), .CLK_SPACE(SPACE), .DATA_OFS(D_OFS)) uut (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_link_idle(i_link_idle),
      .i_an_enable(i_an_enable), .i_an_word(i_an_word),
      .i_tx_active(i_tx_active), .o_pulse(o_pulse),
      .o_burst_busy(o_burst_busy), .o_word_taken(o_word_taken),
      .o_jabber(o_jabber), .o_tx_enable(o_tx_enable));
   tlpj_link_partner far (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_pulse(o_pulse), .o_width(width), .o_period(period),
      .o_data_ofs(d_ofs), .o_n_clk(n_clk), .o_n_data(n_data));
   // clock and hang guard
   always #5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : wait_cyc
   // outputs are read mid-cycle, clear of the edge that launches them
   task automatic settle();
      @(negedge i_mclk);
   endtask : settle
   task automatic wait_taken();
      for (k = 0; k < 12000 && o_word_taken !== 1'b1; k++) @(negedge i_mclk);
   endtask : wait_taken
   // mid-count reset, then trip, hold-off and release on exact edges
   task automatic test_jabber();
      wait_cyc(1);
      i_tx_active <= 1'b1;
      wait_cyc(80);
      i_reset <= 1'b1;
      wait_cyc(2);
      i_reset <= 1'b0;
      wait_cyc(JAB_T - 1);
      settle();
      `CHK(o_jabber, 1'b0)
      wait_cyc(1);
      settle();
      `CHK(o_jabber, 1'b1)
      `CHK(o_tx_enable, 1'b0)
      wait_cyc(1);
      i_tx_active <= 1'b0;
      wait_cyc(JAB_R - 2);
      settle();
      `CHK(o_jabber, 1'b1)
      wait_cyc(1);
      settle();
      `CHK(o_jabber, 1'b0)
      `CHK(o_tx_enable, 1'b1)
   endtask : test_jabber
   // idle link: single pulses at the normal period
   task automatic test_nlp();
      wait_cyc(1);
      i_link_idle <= 1'b1;
      wait_cyc(3 * NLP_P - 40);
      i_link_idle <= 1'b0;
      settle();
      `CHK(width, PULSE_CYC)
      `CHK(period, NLP_P)
   endtask : test_nlp
   // two bursts: pulse counts, spacing, offset and start-to-start period
   task automatic test_burst();
      c0 = n_clk;
      d0 = n_data;
      wait_cyc(1);
      i_an_word <= 16'h8421;
      i_an_enable <= 1'b1;
      wait_taken();
      `CHK(o_word_taken, 1'b1)
      `CHK(o_burst_busy, 1'b1)
      t0 = cycles;
      for (k = 0; k < 4200 && o_burst_busy === 1'b1; k++) @(negedge i_mclk);
      wait_cyc(20);
      settle();
      `CHK(n_clk - c0, BURST_CLKS)
      `CHK(n_data - d0, 4)
      `CHK(period, SPACE)
      `CHK(d_ofs, D_OFS)
      `CHK(width, PULSE_CYC)
      wait_taken();
      `CHK(o_word_taken, 1'b1)
      `CHK(cycles - t0, FLP_P)
      wait_cyc(1);
      i_an_enable <= 1'b0;
   endtask : test_burst
   task automatic conclude();
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   // reset, then each scenario in turn
   initial begin
      {i_mclk, i_link_idle, i_an_enable, i_tx_active} = '0;
      i_an_word = '0;
      i_reset = 1'b1;
      wait_cyc(4);
      settle();
      `CHK(o_tx_enable, 1'b1)
      `CHK(o_pulse, 3'h0)
      wait_cyc(1);
      i_reset <= 1'b0;
      wait_cyc(2);
      settle();
      `CHK(o_jabber, 1'b0)
      test_jabber();
      test_nlp();
      test_burst();
      conclude();
   end
endmodule : test_tenbase_link_pulse_jabber_timer

// >>> tlpj_link_partner.sv
`timescale 1ns/1ps
// far-end receiver on the pair: measures pulse width and spacing
module tlpj_link_partner
   import tlpj_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire tlpj_pulse_t i_pulse,
   output int               o_width,
   output int               o_period,
   output int               o_data_ofs,
   output int               o_n_clk,
   output int               o_n_data
);
   int   run_cnt;
   int   since_tim;
   int   since_clk;
   logic pulse_q;
   wire  rise = i_pulse.pulse && !pulse_q;
   // track rises, falls and gaps seen on the line
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         {run_cnt, since_tim, since_clk, o_width, o_period} <= '0;
         {o_data_ofs, o_n_clk, o_n_data} <= '0;
         pulse_q <= 1'b0;
      end else begin
         pulse_q   <= i_pulse.pulse;
         run_cnt   <= i_pulse.pulse ? run_cnt + 1 : 0;
         since_tim <= (rise && !i_pulse.is_data) ? 0 : since_tim + 1;
         since_clk <= (rise && i_pulse.is_clk) ? 0 : since_clk + 1;
         if (!i_pulse.pulse && pulse_q) o_width <= run_cnt;
         if (rise && !i_pulse.is_data) o_period <= since_tim + 1;
         if (rise && i_pulse.is_data) o_data_ofs <= since_clk + 1;
         if (rise && i_pulse.is_clk) o_n_clk <= o_n_clk + 1;
         if (rise && i_pulse.is_data) o_n_data <= o_n_data + 1;
      end
   end
endmodule : tlpj_link_partner

// >>> tlpj_link_timer.sv
`timescale 1ns/1ps
// Functional notes
// - jabber trips after 85 ms continuous transmit
// - jabber holds transmitter off, releases after 500 ms
// - idle link sends 100 ns pulse every 16 ms
// - burst clock and data pulses 100 ns wide
// - burst clock pulses spaced 125 us apart
// - one bit puts data pulse 62 us after clock
// - burst lasts 2 ms first to last pulse
// - new burst every 16 ms during negotiation
module tlpj_link_timer
   import tlpj_pkg::*;
#(
   parameter int unsigned NLP_PERIOD   = NLP_CYC,
   parameter int unsigned FLP_PERIOD   = FLP_CYC,
   parameter int unsigned JAB_ON       = JAB_ON_CYC,
   parameter int unsigned JAB_OFF      = JAB_OFF_CYC,
   parameter int unsigned CLK_SPACE    = CLK_SPACE_CYC,
   parameter int unsigned DATA_OFS     = DATA_OFS_CYC
) (
   input  wire logic                 i_mclk,
   input  wire logic                 i_reset,
   input  wire logic                 i_link_idle,
   input  wire logic                 i_an_enable,
   input  wire logic [WORD_BITS-1:0] i_an_word,
   input  wire logic                 i_tx_active,
   output tlpj_pulse_t               o_pulse,
   output logic                      o_burst_busy,
   output logic                      o_word_taken,
   output logic                      o_jabber,
   output logic                      o_tx_enable
);

   typedef struct packed {
      tlpj_mode_t       mode;
      logic [31:0]      per_cnt;    // period counter, nlp or burst interval
      logic [31:0]      slot_cnt;   // counter within one clock slot
      logic [4:0]       clk_idx;    // clock pulse index within burst
      logic [WORD_BITS-1:0] word;
      logic [7:0]       wid_cnt;    // remaining pulse width cycles
      logic             is_clk;
      logic             is_data;
      logic [31:0]      jab_cnt;
      logic             jabber;
      logic             taken;
   } tlpj_state_t;

   tlpj_state_t st_reg;
   tlpj_state_t st_next;

   localparam logic [7:0] WID = 8'(PULSE_CYC);

   // pulse counters, burst sequencer and jabber timer
   always_comb begin
      st_next       = st_reg;
      st_next.taken = 1'b0;
      // pulse width countdown
      if (st_reg.wid_cnt != 8'h00) begin
         st_next.wid_cnt = st_reg.wid_cnt - 8'h01;
      end else begin
         st_next.is_clk  = 1'b0;
         st_next.is_data = 1'b0;
      end
      unique case (st_reg.mode)
         TLPJ_IDLE: begin
            st_next.per_cnt = 32'h0;
            if (i_an_enable) begin
               st_next.mode = TLPJ_GAP;
               st_next.per_cnt = 32'(FLP_PERIOD - 1);
            end else if (i_link_idle) begin
               st_next.mode = TLPJ_NLP;
               st_next.per_cnt = 32'(NLP_PERIOD - 1);
            end
         end
         TLPJ_NLP: begin
            if (i_an_enable || !i_link_idle) begin
               st_next.mode = TLPJ_IDLE;
            end else if (st_reg.per_cnt == 32'(NLP_PERIOD - 1)) begin
               st_next.per_cnt = 32'h0;
               st_next.wid_cnt = WID - 8'h01;
               st_next.is_clk  = 1'b1;
            end else begin
               st_next.per_cnt = st_reg.per_cnt + 32'h1;
            end
         end
         TLPJ_GAP: begin
            if (!i_an_enable) begin
               st_next.mode = TLPJ_IDLE;
            end else if (st_reg.per_cnt == 32'(FLP_PERIOD - 1)) begin
               // burst start: first clock pulse, latch word
               st_next.mode     = TLPJ_BURST;
               st_next.per_cnt  = 32'h0;
               st_next.slot_cnt = 32'h0;
               st_next.clk_idx  = 5'h0;
               st_next.word     = i_an_word;
               st_next.taken    = 1'b1;
               st_next.wid_cnt  = WID - 8'h01;
               st_next.is_clk   = 1'b1;
            end else begin
               st_next.per_cnt = st_reg.per_cnt + 32'h1;
            end
         end
         TLPJ_BURST: begin
            st_next.per_cnt  = st_reg.per_cnt + 32'h1;
            st_next.slot_cnt = st_reg.slot_cnt + 32'h1;
            if (!i_an_enable) begin
               st_next.mode = TLPJ_IDLE;
            end else if (st_reg.slot_cnt == 32'(DATA_OFS - 1)
                         && st_reg.clk_idx != 5'(BURST_CLKS - 1)) begin
               // data slot: pulse only for a one bit
               if (st_reg.word[0]) begin
                  st_next.wid_cnt = WID - 8'h01;
                  st_next.is_data = 1'b1;
               end
            end else if (st_reg.slot_cnt == 32'(CLK_SPACE - 1)) begin
               st_next.slot_cnt = 32'h0;
               st_next.clk_idx  = st_reg.clk_idx + 5'h1;
               st_next.word     = {1'b0, st_reg.word[WORD_BITS-1:1]};
               st_next.wid_cnt  = WID - 8'h01;
               st_next.is_clk   = 1'b1;
               if (st_reg.clk_idx == 5'(BURST_CLKS - 2)) begin
                  st_next.mode = TLPJ_GAP;
               end
            end
         end
         default: st_next.mode = TLPJ_IDLE;
      endcase
      // jabber: count continuous transmit, then hold off
      if (st_reg.jabber) begin
         if (st_reg.jab_cnt == 32'(JAB_OFF - 1)) begin
            st_next.jabber  = 1'b0;
            st_next.jab_cnt = 32'h0;
         end else begin
            st_next.jab_cnt = st_reg.jab_cnt + 32'h1;
         end
      end else if (!i_tx_active) begin
         st_next.jab_cnt = 32'h0;
      end else if (st_reg.jab_cnt == 32'(JAB_ON - 1)) begin
         st_next.jabber  = 1'b1;
         st_next.jab_cnt = 32'h0;
      end else begin
         st_next.jab_cnt = st_reg.jab_cnt + 32'h1;
      end
   end

   // state register, cleared by reset
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   assign o_pulse.pulse   = st_reg.is_clk | st_reg.is_data;
   assign o_pulse.is_clk  = st_reg.is_clk;
   assign o_pulse.is_data = st_reg.is_data;
   assign o_burst_busy    = (st_reg.mode == TLPJ_BURST);
   assign o_word_taken    = st_reg.taken;
   assign o_jabber        = st_reg.jabber;
   assign o_tx_enable     = ~st_reg.jabber;

   // pulse lasts exactly ten cycles, split in two runs to keep unrolling small
   a_pulse_width: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(o_pulse.pulse) |-> o_pulse.pulse [*5]
      ##1 o_pulse.pulse [*5] ##1 !o_pulse.pulse)
      else $error("link pulse width wrong");
   // normal pulses only start when the period count expires
   a_nlp_spacing: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_reg.mode == TLPJ_NLP && $rose(o_pulse.is_clk))
      |-> $past(st_reg.per_cnt) == 32'(NLP_PERIOD - 1))
      else $error("normal pulse issued off its period");
   a_zero_empty: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_reg.mode == TLPJ_BURST && st_reg.slot_cnt == 32'(DATA_OFS - 1)
       && !st_reg.word[0]) |=> !o_pulse.is_data)
      else $error("data pulse sent for zero bit");
   a_one_data: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_reg.mode == TLPJ_BURST && i_an_enable
       && st_reg.slot_cnt == 32'(DATA_OFS - 1)
       && st_reg.clk_idx != 5'(BURST_CLKS - 1) && st_reg.word[0])
      |=> $rose(o_pulse.is_data))
      else $error("data pulse missing for one bit");
   a_clk_space: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_burst_busy && i_an_enable && st_reg.slot_cnt == 32'(CLK_SPACE - 1))
      |=> $rose(o_pulse.is_clk) && st_reg.slot_cnt == 32'h0)
      else $error("clock pulse spacing wrong");
   a_burst_end: assert property (@(posedge i_mclk) disable iff (i_reset)
      $fell(o_burst_busy) && i_an_enable |-> st_reg.clk_idx
      == 5'(BURST_CLKS - 1)
      && st_reg.per_cnt == 32'((BURST_CLKS - 1) * CLK_SPACE))
      else $error("burst length wrong");
   a_jab_trip: assert property (@(posedge i_mclk) disable iff (i_reset)
      (!o_jabber && i_tx_active && st_reg.jab_cnt == 32'(JAB_ON - 1))
      |=> o_jabber && !o_tx_enable)
      else $error("jabber did not trip");
   a_jab_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(o_jabber) |-> !o_tx_enable [*8])
      else $error("transmitter not held off");
   // no transmit activity means jabber can never trip
   a_jab_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
      (!o_jabber && !i_tx_active) |=> !o_jabber)
      else $error("jabber tripped without transmit");
   // hold-off ends when its count expires, transmitter comes back
   a_jab_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_jabber && st_reg.jab_cnt == 32'(JAB_OFF - 1))
      |=> !o_jabber && o_tx_enable)
      else $error("jabber not released");
   // bursts start one full burst period apart
   a_burst_gap: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(o_burst_busy)
      |-> $past(st_reg.per_cnt) == 32'(FLP_PERIOD - 1))
      else $error("burst period wrong");
   // a burst opens with a clock pulse and takes the word
   a_word_latch: assert property (@(posedge i_mclk) disable iff (i_reset)
      $rose(o_burst_busy)
      |-> o_word_taken && o_pulse.is_clk)
      else $error("burst start without word or clock");
   // idle mode never launches a pulse
   a_idle_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_reg.mode == TLPJ_IDLE && !o_pulse.pulse)
      |=> !o_pulse.pulse)
      else $error("pulse launched from idle");

endmodule : tlpj_link_timer

// >>> tlpj_pkg.sv
package tlpj_pkg;

   // clock rate and derived timing
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned NS_PER_CLK   = 1_000_000_000 / CLK_HZ;
   localparam int unsigned PULSE_NS     = 100;
   localparam int unsigned PULSE_CYC    = PULSE_NS / NS_PER_CLK;
   localparam int unsigned CLK_SPACE_US = 125;
   localparam int unsigned CLK_SPACE_CYC = CLK_SPACE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DATA_OFS_US  = 62;
   localparam int unsigned DATA_OFS_CYC = DATA_OFS_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BURST_MS     = 2;
   localparam int unsigned NLP_MS       = 16;
   localparam int unsigned FLP_MS       = 16;
   localparam int unsigned JAB_ON_MS    = 85;
   localparam int unsigned JAB_OFF_MS   = 500;
   localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
   localparam int unsigned NLP_CYC      = NLP_MS * CYC_PER_MS;
   localparam int unsigned FLP_CYC      = FLP_MS * CYC_PER_MS;
   localparam int unsigned JAB_ON_CYC   = JAB_ON_MS * CYC_PER_MS;
   localparam int unsigned JAB_OFF_CYC  = JAB_OFF_MS * CYC_PER_MS;
   // clock pulses in one burst: 2 ms / 125 us = 16 slots, 17 clock pulses
   localparam int unsigned BURST_CLKS   = (BURST_MS * 1000) / CLK_SPACE_US + 1;
   localparam int unsigned WORD_BITS    = 16;

   typedef enum logic [1:0] {
      TLPJ_IDLE  = 2'b00,
      TLPJ_NLP   = 2'b01,
      TLPJ_BURST = 2'b10,
      TLPJ_GAP   = 2'b11
   } tlpj_mode_t;

   // link pulse outputs
   typedef struct packed {
      logic pulse;    // pulse driven onto the pair
      logic is_clk;   // current pulse is a clock pulse, burst or normal link pulse
      logic is_data;  // current pulse is a burst data pulse
   } tlpj_pulse_t;

endpackage : tlpj_pkg
